// >>> mfws_host.sv
// Host controller model on the report and instruction side.
// Assumes one clock shared with the supervisor.
`timescale 1ns/100ps
module mfws_host (
    // Clock
    input wire logic clk,
    // Report
    input wire logic tx_valid,
    input wire logic [15:0] tx_err,
    output logic tx_ready,
    // Drive instruction
    output logic cmd_valid,
    output mfws_pkg::mfws_cmd_t cmd
);
    int slow = 1;
    int acks = 0;
    int w = 0;
    logic [15:0] last_err = 16'h0000;
    initial
    begin
        tx_ready = 0;
        cmd_valid = 0;
        cmd = '0;
    end
    ////////////////////////////////////////
    // Accept after a short stall; err taken at the accepting edge
    always @(posedge clk)
    begin
        if (tx_ready)
        begin
            acks++;
            last_err <= tx_err;
            tx_ready <= 1'b0;
        end
        else if (tx_valid)
        begin
            w++;
            if (w > slow)
            begin
                w = 0;
                tx_ready <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////
    task automatic send(input logic [7:0] op, input logic [15:0] s, input logic [15:0] a, input logic [15:0] c);
        @(posedge clk);
        cmd <= '{op, s, a, c};
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Released lines must not keep the last value
        cmd <= ~cmd;
        #1;
    endtask
endmodule

// >>> mfws_pkg.sv
// Constants and carrier types for the motor fault and warning supervisor.
// Assumes measurements arrive already scaled to tenths of their unit.
package mfws_pkg;

    // Clock and time base
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

    // Times in milliseconds (one tick each)
    localparam logic [15:0] STALL_ERR_MS = 16'h3E80;  // 16 s
    localparam logic [15:0] STALL_WARN_MS = 16'h07D0; // 2 s
    localparam logic [15:0] LINK_ERR_MS = 16'h01F4;   // 0.5 s
    localparam logic [15:0] OVL_ERR_MS = 16'h3E80;    // 16 s cumulative
    localparam logic [15:0] OVL_WARN_MS = 16'h2710;   // 10 s cumulative
    localparam logic [15:0] OVL_COOL_MS = 16'h61A8;   // 25 s
    localparam logic [15:0] TX_PERIOD_MS = 16'h0064;  // 100 ms

    // Thresholds, tenths of degC / r/min / V / A
    localparam logic [15:0] TEMP_ERR_SET = 16'h03E8;  // 100.0
    localparam logic [15:0] TEMP_WARN_SET = 16'h0384; // 90.0
    localparam logic [15:0] TEMP_CLR = 16'h02EE;      // 75.0
    localparam logic [15:0] SPD_ERR_SET = 16'hD6D8;   // 5500.0
    localparam logic [15:0] SPD_WARN_SET = 16'hC350;  // 5000.0
    localparam logic [15:0] SPD_WARN_CLR = 16'hBB80;  // 4800.0
    localparam logic [15:0] SPD_STOPPED = 16'h0005;   // 0.5
    localparam logic [15:0] UV_ERR_SET = 16'h0096;    // 15.0
    localparam logic [15:0] UV_ERR_CLR = 16'h00A5;    // 16.5
    localparam logic [15:0] UV_WARN_SET = 16'h00A5;   // 16.5
    localparam logic [15:0] UV_WARN_CLR = 16'h00AA;   // 17.0
    localparam logic [15:0] OV_ERR_SET = 16'h0276;    // 63.0
    localparam logic [15:0] OV_ERR_CLR = 16'h0262;    // 61.0
    localparam logic [15:0] OV_WARN_SET = 16'h0258;   // 60.0
    localparam logic [15:0] OV_WARN_CLR = 16'h0244;   // 58.0
    localparam logic [15:0] OC_ERR_SET = 16'h01FE;    // 51.0 peak
    localparam logic [15:0] OVL_I_ON = 16'h00D2;      // 21.0
    localparam logic [15:0] OVL_I_OFF = 16'h00C3;     // 19.5
    localparam logic [11:0] ADC_OFS_MAX = 12'h19A;    // 410

    // Command ranges
    localparam logic [15:0] SPD_MIN = 16'h0000;
    localparam logic [15:0] SPD_MAX = 16'hAFC8;
    localparam logic [15:0] ACC_MIN = 16'h000A;
    localparam logic [15:0] ACC_MAX = 16'h2710;
    localparam logic [15:0] CUR_MIN = 16'h0032;
    localparam logic [15:0] CUR_MAX = 16'h01F4;

    // Error and warning bit positions
    localparam int B_HEAT = 0;
    localparam int B_SPEED = 1;
    localparam int B_UV = 2;
    localparam int B_OV = 3;
    localparam int B_STALL = 4;
    localparam int B_SENSOR = 5;
    localparam int B_LINK = 6;
    localparam int B_OVL = 8;
    localparam int B_ADC = 12;
    localparam int B_SYS = 13;
    localparam int B_OC = 14;
    localparam int B_IC = 15;

    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ERR = 8'h04;
    localparam logic [7:0] REG_WARN = 8'h08;
    localparam logic [7:0] REG_SPD = 8'h0C;
    localparam logic [7:0] REG_CUR = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    typedef struct packed {
        logic [15:0] temp1;
        logic [15:0] temp2;
        logic [15:0] speed;
        logic [15:0] volt;
        logic [15:0] iphase;
    } mfws_meas_t;

    typedef struct packed {
        logic [7:0] op_state;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] cur_lim;
    } mfws_cmd_t;

endpackage

// >>> mfws_top.sv
// Fault and warning supervisor: error and warning words, drive gating, command clamping.
// Assumes all inputs synchronous to clk; CAN framing is done outside.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
module mfws_top #(
    parameter int TICK_CYCLES = mfws_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [31:0] rdata,
    // Measurements and fault inputs
    input wire mfws_pkg::mfws_meas_t meas,
    input wire logic sensor_fault,
    input wire logic pos_fault,
    input wire logic sys_fault,
    input wire logic ic_fault,
    input wire logic adc_ofs_valid,
    input wire logic [11:0] adc_ofs,
    // Drive instruction from CAN
    input wire logic cmd_valid,
    input wire mfws_pkg::mfws_cmd_t cmd,
    input wire logic link_fail,
    // Report to CAN
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [15:0] tx_err,
    output logic [15:0] tx_warn,
    // Drive outputs
    output logic drive_en,
    output logic [15:0] spd_target,
    output logic [15:0] acc_target,
    output logic [15:0] cur_limit
);

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic tick;

    always_comb
    begin
        tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
        tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tick_cnt_reg <= 32'h0000_0000;
        else
            tick_cnt_reg <= tick_cnt_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command capture with saturation
    function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        sat = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    logic [7:0] op_reg, op_next;
    logic [15:0] spd_reg, spd_next;
    logic [15:0] acc_reg, acc_next;
    logic [15:0] cur_reg, cur_next;

    always_comb
    begin
        op_next = op_reg;
        spd_next = spd_reg;
        acc_next = acc_reg;
        cur_next = cur_reg;
        if (cmd_valid)
        begin
            op_next = cmd.op_state;
            spd_next = sat(cmd.speed, mfws_pkg::SPD_MIN, mfws_pkg::SPD_MAX);
            acc_next = sat(cmd.accel, mfws_pkg::ACC_MIN, mfws_pkg::ACC_MAX);
            cur_next = sat(cmd.cur_lim, mfws_pkg::CUR_MIN, mfws_pkg::CUR_MAX);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            op_reg <= 8'h00;
            spd_reg <= mfws_pkg::SPD_MIN;
            acc_reg <= mfws_pkg::ACC_MIN;
            cur_reg <= mfws_pkg::CUR_MIN;
        end
        else
        begin
            op_reg <= op_next;
            spd_reg <= spd_next;
            acc_reg <= acc_next;
            cur_reg <= cur_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time-in-condition counters
    logic [15:0] stall_cnt_reg, stall_cnt_next;
    logic [15:0] link_cnt_reg, link_cnt_next;
    logic [15:0] ovl_cnt_reg, ovl_cnt_next;
    logic [15:0] cool_cnt_reg, cool_cnt_next;
    logic [15:0] derate_reg, derate_next;
    logic [15:0] err_reg, err_next;
    logic [15:0] warn_reg, warn_next;
    logic running, idle, below, link_ok_cmd;
    logic [18:0] spd_x5, cmd_x4;

    always_comb
    begin
        running = op_reg[0];
        idle = (op_reg == 8'h00);
        spd_x5 = 19'(meas.speed) * 19'h0_0005;
        cmd_x4 = 19'(spd_reg) * 19'h0_0004;
        below = running && (spd_x5 < cmd_x4);
        link_ok_cmd = cmd_valid && !link_fail;
        stall_cnt_next = stall_cnt_reg;
        if (!below)
            stall_cnt_next = 16'h0000;
        else if (tick && stall_cnt_reg != 16'hFFFF)
            stall_cnt_next = stall_cnt_reg + 16'h0001;
        link_cnt_next = link_cnt_reg;
        if (link_ok_cmd || !running)
            link_cnt_next = 16'h0000;
        else if (tick && link_cnt_reg != 16'hFFFF)
            link_cnt_next = link_cnt_reg + 16'h0001;
        ovl_cnt_next = ovl_cnt_reg;
        if (tick && meas.iphase >= mfws_pkg::OVL_I_ON && ovl_cnt_reg != 16'hFFFF)
            ovl_cnt_next = ovl_cnt_reg + 16'h0001;
        else if (tick && meas.iphase <= mfws_pkg::OVL_I_OFF && ovl_cnt_reg != 16'h0000)
            ovl_cnt_next = ovl_cnt_reg - 16'h0001;
        cool_cnt_next = cool_cnt_reg;
        if (!err_reg[mfws_pkg::B_OVL])
            cool_cnt_next = 16'h0000;
        else if (tick && cool_cnt_reg != 16'hFFFF)
            cool_cnt_next = cool_cnt_reg + 16'h0001;
        // Derating ramps down one step per tick, so derating never cuts cur_limit abruptly
        derate_next = derate_reg;
        if (tick && warn_reg[mfws_pkg::B_OVL] && derate_reg < mfws_pkg::CUR_MAX)
            derate_next = derate_reg + 16'h0001;
        else if (tick && !warn_reg[mfws_pkg::B_OVL] && derate_reg != 16'h0000)
            derate_next = derate_reg - 16'h0001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stall_cnt_reg <= 16'h0000;
            link_cnt_reg <= 16'h0000;
            ovl_cnt_reg <= 16'h0000;
            cool_cnt_reg <= 16'h0000;
            derate_reg <= 16'h0000;
        end
        else
        begin
            stall_cnt_reg <= stall_cnt_next;
            link_cnt_reg <= link_cnt_next;
            ovl_cnt_reg <= ovl_cnt_next;
            cool_cnt_reg <= cool_cnt_next;
            derate_reg <= derate_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error and warning words; set always wins over clear
    logic [15:0] e_set, e_clr, w_set, w_clr;
    logic [15:0] tmax;

    always_comb
    begin
        tmax = (meas.temp1 > meas.temp2) ? meas.temp1 : meas.temp2;
        e_set = 16'h0000;
        e_clr = 16'h0000;
        w_set = 16'h0000;
        w_clr = 16'h0000;
        e_set[mfws_pkg::B_HEAT] = tmax >= mfws_pkg::TEMP_ERR_SET;
        e_clr[mfws_pkg::B_HEAT] = tmax <= mfws_pkg::TEMP_CLR && idle;
        e_set[mfws_pkg::B_SPEED] = meas.speed >= mfws_pkg::SPD_ERR_SET;
        e_clr[mfws_pkg::B_SPEED] = meas.speed <= mfws_pkg::SPD_STOPPED && idle;
        e_set[mfws_pkg::B_UV] = meas.volt <= mfws_pkg::UV_ERR_SET;
        e_clr[mfws_pkg::B_UV] = meas.volt >= mfws_pkg::UV_ERR_CLR && idle;
        e_set[mfws_pkg::B_OV] = meas.volt >= mfws_pkg::OV_ERR_SET;
        e_clr[mfws_pkg::B_OV] = meas.volt <= mfws_pkg::OV_ERR_CLR && idle;
        e_set[mfws_pkg::B_STALL] = stall_cnt_next >= mfws_pkg::STALL_ERR_MS;
        e_clr[mfws_pkg::B_STALL] = meas.speed <= mfws_pkg::SPD_STOPPED && idle;
        e_set[mfws_pkg::B_SENSOR] = sensor_fault || pos_fault;
        e_set[mfws_pkg::B_LINK] = running && link_cnt_next >= mfws_pkg::LINK_ERR_MS;
        e_clr[mfws_pkg::B_LINK] = cmd_valid;
        e_set[mfws_pkg::B_OVL] = ovl_cnt_next >= mfws_pkg::OVL_ERR_MS;
        e_clr[mfws_pkg::B_OVL] = cool_cnt_reg >= mfws_pkg::OVL_COOL_MS && idle;
        e_set[mfws_pkg::B_ADC] = adc_ofs_valid && adc_ofs >= mfws_pkg::ADC_OFS_MAX;
        e_set[mfws_pkg::B_SYS] = sys_fault;
        e_set[mfws_pkg::B_OC] = meas.iphase >= mfws_pkg::OC_ERR_SET;
        e_set[mfws_pkg::B_IC] = ic_fault;
        w_set[mfws_pkg::B_HEAT] = tmax >= mfws_pkg::TEMP_WARN_SET;
        w_clr[mfws_pkg::B_HEAT] = tmax <= mfws_pkg::TEMP_CLR;
        w_set[mfws_pkg::B_SPEED] = meas.speed >= mfws_pkg::SPD_WARN_SET;
        w_clr[mfws_pkg::B_SPEED] = meas.speed <= mfws_pkg::SPD_WARN_CLR;
        w_set[mfws_pkg::B_UV] = meas.volt <= mfws_pkg::UV_WARN_SET;
        w_clr[mfws_pkg::B_UV] = meas.volt >= mfws_pkg::UV_WARN_CLR;
        w_set[mfws_pkg::B_OV] = meas.volt >= mfws_pkg::OV_WARN_SET;
        w_clr[mfws_pkg::B_OV] = meas.volt <= mfws_pkg::OV_WARN_CLR;
        w_set[mfws_pkg::B_STALL] = stall_cnt_next >= mfws_pkg::STALL_WARN_MS;
        w_clr[mfws_pkg::B_STALL] = !below || idle;
        w_set[mfws_pkg::B_OVL] = ovl_cnt_next >= mfws_pkg::OVL_WARN_MS;
        w_clr[mfws_pkg::B_OVL] = ovl_cnt_next < mfws_pkg::OVL_WARN_MS;
        // Bits without a clear term hold until reset (power cycle)
        err_next = e_set | (err_reg & ~e_clr);
        warn_next = w_set | (warn_reg & ~w_clr);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            err_reg <= 16'h0000;
            warn_reg <= 16'h0000;
        end
        else
        begin
            err_reg <= err_next;
            warn_reg <= warn_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive outputs
    always_comb
    begin
        drive_en = running && (err_reg == 16'h0000);
        spd_target = spd_reg;
        acc_target = acc_reg;
        cur_limit = (cur_reg > derate_reg + mfws_pkg::CUR_MIN) ? cur_reg - derate_reg : mfws_pkg::CUR_MIN;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reporting to the host
    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] per_cnt_reg, per_cnt_next;
    logic pend_reg, pend_next;
    logic info_en, per_hit, new_err, new_warn;

    always_comb
    begin
        info_en = ctrl_reg[0];
        per_hit = info_en && tick && per_cnt_reg == mfws_pkg::TX_PERIOD_MS - 16'h0001;
        per_cnt_next = per_cnt_reg;
        if (!info_en || per_hit)
            per_cnt_next = 16'h0000;
        else if (tick)
            per_cnt_next = per_cnt_reg + 16'h0001;
        new_err = (err_next & ~err_reg) != 16'h0000;
        new_warn = (warn_next & ~warn_reg) != 16'h0000;
        // A new event in the handshake cycle keeps the request raised
        pend_next = pend_reg && !(tx_valid && tx_ready);
        if (per_hit || new_err || new_warn)
            pend_next = 1'b1;
        ctrl_next = ctrl_reg;
        if (we && addr == mfws_pkg::REG_CTRL)
            ctrl_next = {31'h0000_0000, wdata[0]};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg <= mfws_pkg::CTRL_RESET;
            per_cnt_reg <= 16'h0000;
            pend_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            per_cnt_reg <= per_cnt_next;
            pend_reg <= pend_next;
        end
    end

    assign tx_valid = pend_reg;
    assign tx_err = err_reg;
    assign tx_warn = warn_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register read port
    logic [31:0] rdata_reg, rdata_next;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (re)
        begin
            unique case (addr)
                mfws_pkg::REG_CTRL: rdata_next = ctrl_reg;
                mfws_pkg::REG_ERR: rdata_next = {16'h0000, err_reg};
                mfws_pkg::REG_WARN: rdata_next = {16'h0000, warn_reg};
                mfws_pkg::REG_SPD: rdata_next = {16'h0000, spd_reg};
                mfws_pkg::REG_CUR: rdata_next = {16'h0000, cur_limit};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_coast;
        (err_reg != 16'h0000) |-> !drive_en;
    endproperty
    a_coast: assert property (p_coast) else $error("drive on with error active");

    property p_heat;
        (tmax >= mfws_pkg::TEMP_ERR_SET) |=> err_reg[mfws_pkg::B_HEAT] && !drive_en;
    endproperty
    a_heat: assert property (p_heat) else $error("overheat error not raised");

    property p_heat_hold;
        err_reg[mfws_pkg::B_HEAT] && !idle |=> err_reg[mfws_pkg::B_HEAT];
    endproperty
    a_heat_hold: assert property (p_heat_hold) else $error("overheat error cleared while active");

    property p_speed;
        (meas.speed >= mfws_pkg::SPD_ERR_SET) |=> err_reg[mfws_pkg::B_SPEED];
    endproperty
    a_speed: assert property (p_speed) else $error("overspeed error not raised");

    property p_uv;
        (meas.volt <= mfws_pkg::UV_ERR_SET) |=> err_reg[mfws_pkg::B_UV] && warn_reg[mfws_pkg::B_UV];
    endproperty
    a_uv: assert property (p_uv) else $error("low voltage not flagged");

    property p_ov;
        (meas.volt >= mfws_pkg::OV_ERR_SET) |=> err_reg[mfws_pkg::B_OV] && warn_reg[mfws_pkg::B_OV];
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage not flagged");

    property p_sensor_sticky;
        err_reg[mfws_pkg::B_SENSOR] |=> err_reg[mfws_pkg::B_SENSOR] [*3];
    endproperty
    a_sensor_sticky: assert property (p_sensor_sticky) else $error("sensor error dropped");

    property p_link_clear;
        cmd_valid && !link_fail |=> !err_reg[mfws_pkg::B_LINK];
    endproperty
    a_link_clear: assert property (p_link_clear) else $error("link error not cleared");

    property p_oc;
        (meas.iphase >= mfws_pkg::OC_ERR_SET) |=> err_reg[mfws_pkg::B_OC] ##1 err_reg[mfws_pkg::B_OC];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent error not held");

    property p_warn_heat;
        (tmax >= mfws_pkg::TEMP_WARN_SET) |=> warn_reg[mfws_pkg::B_HEAT];
    endproperty
    a_warn_heat: assert property (p_warn_heat) else $error("overheat warning missing");

    property p_clamp;
        cmd_valid && cmd.speed > mfws_pkg::SPD_MAX |=> spd_target == mfws_pkg::SPD_MAX;
    endproperty
    a_clamp: assert property (p_clamp) else $error("speed not saturated");

    property p_report;
        new_err && !tx_valid |=> tx_valid;
    endproperty
    a_report: assert property (p_report) else $error("new error not reported");

    c_run: cover property (cmd_valid && cmd.op_state[0] ##1 drive_en);
    c_err_stop: cover property (drive_en ##1 !drive_en && err_reg != 16'h0000);
    c_tx: cover property (tx_valid && tx_ready);

endmodule

// >>> tb_top.sv
// Self-checking bench for the fault and warning supervisor.
// Assumes the host model answers reports and sends instructions.
`timescale 1ns/100ps
module tb_top;
    logic clk = 0;
    logic rst = 1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic we = 0;
    logic re = 0;
    logic [31:0] rdata;
    logic [4:0] flt = 5'h00;
    logic [11:0] adc_ofs = 12'h000;
    logic link_fail = 1'b0;
    logic cmd_valid, tx_valid, tx_ready, drive_en;
    logic [15:0] tx_err, tx_warn, spd_target, acc_target, cur_limit, ew;
    mfws_pkg::mfws_cmd_t cmd;
    mfws_pkg::mfws_meas_t meas, m, idle_m;
    logic [15:0] tval [8] = '{16'h03E8, 16'h0384, 16'hD6D8, 16'hC350, 16'h0096, 16'h00A5, 16'h0276, 16'h0258};
    int err_total = 0;
    int cmp_count = 0;
    int n;
    always #5 clk = ~clk;
    // Short tick keeps the timers within the run
    mfws_top #(.TICK_CYCLES(10)) i_mfws_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .meas(meas), .sensor_fault(flt[0]), .pos_fault(flt[1]), .sys_fault(flt[2]),
        .ic_fault(flt[3]), .adc_ofs_valid(flt[4]), .adc_ofs(adc_ofs), .cmd_valid(cmd_valid), .cmd(cmd),
        .link_fail(link_fail), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_err(tx_err), .tx_warn(tx_warn),
        .drive_en(drive_en), .spd_target(spd_target), .acc_target(acc_target), .cur_limit(cur_limit));
    mfws_host i_mfws_host (.clk(clk), .tx_valid(tx_valid), .tx_err(tx_err), .tx_ready(tx_ready),
        .cmd_valid(cmd_valid), .cmd(cmd));
    ////////////////////////////////////////
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic setm(input mfws_pkg::mfws_meas_t v);
        @(posedge clk);
        meas <= v;
        tick(6);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1;
        @(posedge clk);
        re <= 0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1;
        @(posedge clk);
        we <= 0;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1;
        repeat (6) @(posedge clk);
        rst <= 0;
        #1;
    endtask
    ////////////////////////////////////////
    initial
    begin
        idle_m = '{16'h00FA, 16'h00FA, 16'h0000, 16'h00F0, 16'h0000};
        meas = idle_m;
        do_reset();
        chk({tx_err, tx_warn}, 0);
        chk({spd_target, acc_target, cur_limit}, {16'h0, mfws_pkg::ACC_MIN, mfws_pkg::CUR_MIN});
        rd(mfws_pkg::REG_CTRL, 1);
        rd(8'h14, 0);
        i_mfws_host.send(8'h01, 16'hFFFF, 16'h0000, 16'h0000);
        chk({spd_target, acc_target, cur_limit}, {mfws_pkg::SPD_MAX, mfws_pkg::ACC_MIN, mfws_pkg::CUR_MIN});
        chk(drive_en, 1);
        rd(mfws_pkg::REG_SPD, mfws_pkg::SPD_MAX);
        // Stall builds while instructions keep the link alive
        n = 0;
        while (tx_warn[mfws_pkg::B_STALL] !== 1'b1 && n < 25)
        begin
            i_mfws_host.send(8'h01, 16'h1000, 16'hFFFF, 16'hFFFF);
            tick(1298);
            n++;
        end
        chk(n, 16);
        chk({spd_target, acc_target, cur_limit}, {16'h1000, mfws_pkg::ACC_MAX, mfws_pkg::CUR_MAX});
        chk({tx_err, drive_en}, 1);
        rd(mfws_pkg::REG_CUR, mfws_pkg::CUR_MAX);
        // A failed instruction leaves the silence timer running
        @(posedge clk);
        link_fail <= 1'b1;
        i_mfws_host.send(8'h01, 16'h1000, 16'hFFFF, 16'hFFFF);
        @(posedge clk);
        link_fail <= 1'b0;
        #1;
        for (n = 0; n < 6000 && tx_err[mfws_pkg::B_LINK] !== 1'b1; n++)
            tick(1);
        chk(n > 3670 && n < 3730, 1);
        if (n == 6000)
            wrap_up();
        chk(drive_en, 0);
        i_mfws_host.send(8'h00, 16'h0000, 16'h0064, 16'h0064);
        // Stall warning drops one edge after the idle setting lands
        tick(1);
        chk({tx_err, tx_warn}, 0);
        // Each threshold: error and warning, then warning only
        for (int i = 0; i < 8; i++)
        begin
            m = idle_m;
            case (i / 2)
                0: m.temp2 = tval[i];
                1: m.speed = tval[i];
                default: m.volt = tval[i];
            endcase
            setm(m);
            ew = (i % 2) ? 16'h0 : 16'h0001 << (i / 2);
            chk({tx_err, tx_warn}, {ew, 16'h0001 << (i / 2)});
            chk(i_mfws_host.last_err, ew);
            i_mfws_host.send(8'h01, 16'h0000, 16'h0064, 16'h0064);
            chk(drive_en, ew == 0);
            setm(idle_m);
            chk({tx_err, tx_warn}, {ew, 16'h0});
            i_mfws_host.send(8'h00, 16'h0000, 16'h0064, 16'h0064);
            tick(2);
            chk(tx_err, 0);
        end
        // Latched faults survive idle; only reset clears them
        m.iphase = mfws_pkg::OC_ERR_SET;
        @(posedge clk);
        flt <= 5'h1F;
        adc_ofs <= mfws_pkg::ADC_OFS_MAX;
        meas <= m;
        @(posedge clk);
        flt <= 5'h00;
        setm(idle_m);
        i_mfws_host.send(8'h00, 16'h0000, 16'h0064, 16'h0064);
        tick(2);
        chk(tx_err, 16'hF020);
        do_reset();
        chk({tx_err, tx_warn}, 0);
        i_mfws_host.acks = 0;
        tick(1100);
        chk(i_mfws_host.acks > 0, 1);
        wr(mfws_pkg::REG_CTRL, 0);
        rd(mfws_pkg::REG_CTRL, 0);
        i_mfws_host.acks = 0;
        tick(2100);
        chk(i_mfws_host.acks, 0);
        m = idle_m;
        m.temp1 = mfws_pkg::TEMP_ERR_SET;
        setm(m);
        tick(2100);
        chk(i_mfws_host.acks, 1);
        rd(mfws_pkg::REG_ERR, 1);
        rd(mfws_pkg::REG_WARN, 1);
        wrap_up();
    end
endmodule
